// ---- src/eetwp_top.sv ----
// Port register plus on-chip serial EEPROM reached over a software-driven two-wire bus.
// Assumes an APB master on pclk and a free-running link clock ee_clk for the memory.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// RQ1: Bit 2 clock, bit 1 data, written level; the code reads bit 1 back as the wire level, low while the memory pulls down.
// RQ2: Data bit one releases line, zero pulls low.
// RQ3: Bit 0 powers memory; zero tri-states its pins.
// RQ4: Power off makes all three bits read zero.
// RQ5: Software makes every edge by register writes.
// RQ6: Memory holds 128 bytes, reachable only serially.
// RQ7: Master changes data only while clock low.
// RQ8: Transfers begin only with both lines high.
// RQ9: Data falling with clock high is START.
// RQ10: Data rising with clock high is STOP.
// RQ11: One bit sampled per clock-high period.
// RQ12: Write keeps last sixteen bytes, oldest overwritten.
// RQ13: Memory acknowledges each byte on extra clock.
// RQ14: No acknowledge while programming is busy.
// RQ15: Acknowledge holds data low through clock high.
// RQ16: Master nack ends read; memory releases data.
module eetwp_top
    import eetwp_pkg::*;
(
    // Register bus clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link clock of the memory.
    input wire logic ee_clk,
    // Observed memory pins.
    output logic ee_vdd_o,
    output logic ee_scl_o,
    output logic ee_scl_oe_n,
    output logic ee_sda_o,
    output logic ee_sda_oe_n
);

    // State of the register side, all on pclk.
    typedef struct packed {
        logic scl;           // Written clock bit.
        logic sda;           // Written data bit.
        logic pwr;           // Written power bit.
        logic [1:0] drv_sync; // Memory pull-down crossing; [0] is the first flop.
        logic [2:0] rdata;   // Captured read value.
        logic pready;        // Access phase answer.
        logic pslverr;       // Unmapped address answer.
        logic vdd_pin;       // Supply pin.
        logic scl_pin;       // Clock pin level.
        logic scl_oe_n;      // Clock pin enable, low while driven.
        logic sda_oe_n;      // Data pin enable, low while pulled low.
    } eetwp_reg_type;

    // State of the memory side, all on ee_clk.
    typedef struct packed {
        logic [1:0] scl_sync;    // Clock bit crossing; [0] is the first flop.
        logic [1:0] sda_sync;    // Data bit crossing.
        logic [1:0] pwr_sync;    // Power bit crossing.
        logic scl_prev;          // Clock level one cycle ago.
        logic sda_prev;          // Wire data level one cycle ago.
        eetwp_link_state_type st; // Protocol state.
        logic [3:0] bit_cnt;     // Bits taken or given in this byte.
        logic [7:0] shift;       // Byte being received or sent.
        logic [1:0] byte_idx;    // 0 control, 1 word address, 2 data.
        logic rd_mode;           // Control byte asked for a read.
        logic ack_ok;            // Master acknowledged the last sent byte.
        logic drive;             // Memory pulls the data line low.
        logic [6:0] addr;        // Current memory address.
        logic [2:0] page;        // Page that the buffered bytes belong to.
        logic [15:0] page_valid; // Buffered bytes waiting for programming.
        logic busy;              // Programming cycle in progress.
        logic [4:0] prog_idx;    // Slot being copied into storage.
        logic [15:0] prog_cnt;   // Cycles left in the programming cycle.
    } eetwp_link_type;

    eetwp_reg_type p_q, p_d;
    eetwp_link_type l_q, l_d;

    // Storage and write page; no reset, as nonvolatile contents are not cleared by it.
    logic [7:0] mem_q [EETWP_MEM_BYTES]; // RQ6
    logic [7:0] pbuf_q [EETWP_PAGE_BYTES];

    // Write strobes and data for the arrays, from the memory side logic.
    logic mem_we;
    logic [6:0] mem_wa;
    logic [7:0] mem_wd;
    logic pbuf_we;
    logic [3:0] pbuf_wa;
    logic [7:0] pbuf_wd;

    // Helper terms of the register side.
    logic hit;
    logic setup;
    logic wr_take;

    // Helper terms of the memory side.
    logic scl_lv;
    logic sda_lv;
    logic pwr_lv;
    logic rise;
    logic fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] rd_byte;

    // Register side next state: APB slave, port bits and pin levels.
    always_comb begin
        p_d = p_q;
        hit = (paddr[11:2] == EETWP_PORT_OFFSET[11:2]);
        setup = psel & ~penable;
        wr_take = psel & penable & p_q.pready & pwrite & hit;
        // Zero wait state: the answer is ready in the first access cycle.
        p_d.pready = setup;
        p_d.pslverr = setup & ~hit;
        p_d.drv_sync = {p_q.drv_sync[0], l_q.drive};
        if (setup) begin
            // A powered-down memory hides every bit of the register.
            if (p_q.pwr && hit) begin
                p_d.rdata = {p_q.scl, p_q.sda & ~p_q.drv_sync[1], 1'b1}; // RQ1
            end else begin
                p_d.rdata = 3'h0; // RQ4
            end
        end
        // A write lands only on the edge that completes the access.
        if (wr_take && pstrb[0]) begin
            p_d.scl = pwdata[EETWP_CLOCK_BIT_POS]; // RQ1 RQ5
            p_d.sda = pwdata[EETWP_DATA_BIT_POS]; // RQ1
            p_d.pwr = pwdata[EETWP_POWER_BIT_POS]; // RQ3
        end
        // Pins follow the port bits one cycle later; clock and data pins float when power is off.
        p_d.vdd_pin = p_q.pwr; // RQ3
        p_d.scl_pin = p_q.scl;
        p_d.scl_oe_n = ~p_q.pwr; // RQ3
        p_d.sda_oe_n = ~(p_q.pwr & (~p_q.sda | p_q.drv_sync[1])); // RQ2 RQ3
    end

    // Register side flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_q <= '{scl: EETWP_PORT_RESET[EETWP_CLOCK_BIT_POS],
                     sda: EETWP_PORT_RESET[EETWP_DATA_BIT_POS],
                     pwr: EETWP_PORT_RESET[EETWP_POWER_BIT_POS],
                     drv_sync: 2'h0, rdata: 3'h0, pready: 1'b0, pslverr: 1'b0,
                     vdd_pin: 1'b1, scl_pin: 1'b1, scl_oe_n: 1'b0, sda_oe_n: 1'b1};
        end else begin
            p_q <= p_d;
        end
    end

    // Outputs straight from flops except ee_sda_o, tied low; upper data bits read as zero.
    assign prdata = {29'h0, p_q.rdata};
    assign pready = p_q.pready;
    assign pslverr = p_q.pslverr;
    assign ee_vdd_o = p_q.vdd_pin;
    assign ee_scl_o = p_q.scl_pin;
    assign ee_scl_oe_n = p_q.scl_oe_n;
    assign ee_sda_o = 1'b0;
    assign ee_sda_oe_n = p_q.sda_oe_n;

    // Memory side next state: wire decoding, protocol and programming.
    always_comb begin
        l_d = l_q;
        mem_we = 1'b0;
        mem_wa = {l_q.page, l_q.prog_idx[3:0]};
        mem_wd = pbuf_q[l_q.prog_idx[3:0]];
        pbuf_we = 1'b0;
        pbuf_wa = l_q.addr[3:0];
        pbuf_wd = l_q.shift;
        rd_byte = mem_q[l_q.addr];
        // Every bit from the register side passes two flops first.
        l_d.scl_sync = {l_q.scl_sync[0], p_q.scl};
        l_d.sda_sync = {l_q.sda_sync[0], p_q.sda};
        l_d.pwr_sync = {l_q.pwr_sync[0], p_q.pwr};
        scl_lv = l_q.scl_sync[1];
        pwr_lv = l_q.pwr_sync[1];
        // Open-drain wire: low if either party pulls it down.
        sda_lv = l_q.sda_sync[1] & ~l_q.drive; // RQ2
        l_d.scl_prev = scl_lv;
        l_d.sda_prev = sda_lv;
        rise = scl_lv & ~l_q.scl_prev;
        fall = ~scl_lv & l_q.scl_prev;
        start_cond = scl_lv & l_q.scl_prev & l_q.sda_prev & ~sda_lv; // RQ9
        stop_cond = scl_lv & l_q.scl_prev & ~l_q.sda_prev & sda_lv; // RQ10

        // Programming walks the sixteen slots, then waits out the cycle.
        if (l_q.busy) begin
            if (!l_q.prog_idx[4]) begin
                mem_we = l_q.page_valid[l_q.prog_idx[3:0]];
                l_d.prog_idx = 5'(l_q.prog_idx + 5'h01);
            end
            if (l_q.prog_cnt == 16'h0000) begin
                l_d.busy = 1'b0;
                l_d.page_valid = 16'h0000;
            end else begin
                l_d.prog_cnt = 16'(l_q.prog_cnt - 16'h0001);
            end
        end

        if (!pwr_lv) begin
            // Supply removed: the memory forgets the transfer and lets go of the line.
            l_d.st = ST_IDLE; // RQ3
            l_d.drive = 1'b0;
            l_d.busy = 1'b0;
            l_d.page_valid = 16'h0000;
        end else if (start_cond) begin
            // A START restarts byte framing, even in the middle of a transfer.
            l_d.st = ST_RECV; // RQ9
            l_d.bit_cnt = 4'h0;
            l_d.byte_idx = 2'h0;
            l_d.drive = 1'b0;
            if (!l_q.busy) begin
                l_d.page_valid = 16'h0000;
            end
        end else if (stop_cond) begin
            // A STOP after written data launches the programming cycle.
            l_d.st = ST_IDLE; // RQ10
            l_d.drive = 1'b0;
            if (!l_q.busy && (l_q.page_valid != 16'h0000)) begin
                l_d.busy = 1'b1;
                l_d.prog_idx = 5'h00;
                l_d.prog_cnt = EETWP_PROG_CYCLES;
            end
        end else begin
            unique case (l_q.st)
                ST_IDLE: begin
                    // Waiting for a START; the lines are not looked at otherwise.
                    l_d.drive = 1'b0;
                end
                ST_RECV: begin
                    if (rise) begin
                        // One bit per clock-high period, taken at its start.
                        l_d.shift = {l_q.shift[6:0], sda_lv}; // RQ11
                        l_d.bit_cnt = 4'(l_q.bit_cnt + 4'h1);
                    end else if (fall && (l_q.bit_cnt == EETWP_BYTE_BITS)) begin
                        l_d.bit_cnt = 4'h0;
                        l_d.st = ST_ACK;
                        l_d.drive = ~l_q.busy; // RQ13 RQ14
                        unique case (l_q.byte_idx)
                            2'h0: begin
                                // Control byte: only our device code is answered.
                                l_d.rd_mode = l_q.shift[0];
                                if ((l_q.shift[7:4] != EETWP_DEV_CODE) || l_q.busy) begin
                                    l_d.drive = 1'b0; // RQ14
                                    l_d.st = ST_IDLE;
                                end
                                l_d.byte_idx = 2'h1;
                            end
                            2'h1: begin
                                l_d.addr = l_q.shift[6:0];
                                l_d.byte_idx = 2'h2;
                            end
                            default: begin
                                // Address wraps in the page, so byte seventeen
                                // overwrites the first one taken.
                                if (!l_q.busy) begin
                                    pbuf_we = 1'b1; // RQ12
                                    l_d.page_valid[l_q.addr[3:0]] = 1'b1; // RQ12
                                    l_d.page = l_q.addr[6:4];
                                    l_d.addr = {l_q.addr[6:4], 4'(l_q.addr[3:0] + 4'h1)};
                                end
                            end
                        endcase
                        if (l_q.busy) begin
                            l_d.st = ST_IDLE; // RQ14
                        end
                    end
                end
                ST_ACK: begin
                    // The pull-down holds from one falling edge to the next,
                    // covering the whole clock-high period.
                    if (fall) begin
                        l_d.drive = 1'b0; // RQ15
                        if (l_q.rd_mode) begin
                            l_d.shift = rd_byte;
                            l_d.drive = ~rd_byte[7];
                            l_d.addr = 7'(l_q.addr + 7'h01);
                            l_d.st = ST_SEND;
                        end else begin
                            l_d.st = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    // Data moves only on falling edges so the line is stable while high.
                    if (fall) begin
                        l_d.bit_cnt = 4'(l_q.bit_cnt + 4'h1);
                        l_d.shift = {l_q.shift[6:0], 1'b1};
                        if (l_q.bit_cnt == 4'(EETWP_BYTE_BITS - 4'h1)) begin
                            l_d.drive = 1'b0;
                            l_d.st = ST_RACK;
                        end else begin
                            l_d.drive = ~l_q.shift[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (rise) begin
                        l_d.ack_ok = ~sda_lv; // RQ13
                    end else if (fall) begin
                        l_d.bit_cnt = 4'h0;
                        if (l_q.ack_ok) begin
                            l_d.shift = rd_byte;
                            l_d.drive = ~rd_byte[7];
                            l_d.addr = 7'(l_q.addr + 7'h01);
                            l_d.st = ST_SEND;
                        end else begin
                            // No acknowledge from the master: keep the line high.
                            l_d.drive = 1'b0; // RQ16
                            l_d.st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    l_d.st = ST_IDLE;
                    l_d.drive = 1'b0;
                end
            endcase
        end
    end

    // Memory side flops; presetn is used asynchronously in this domain too.
    always_ff @(posedge ee_clk or negedge presetn) begin
        if (!presetn) begin
            l_q <= '{scl_sync: 2'h0, sda_sync: 2'h0, pwr_sync: 2'h0, scl_prev: 1'b0,
                     sda_prev: 1'b0, st: ST_IDLE, bit_cnt: 4'h0, shift: 8'h00,
                     byte_idx: 2'h0, rd_mode: 1'b0, ack_ok: 1'b0, drive: 1'b0,
                     addr: 7'h00, page: 3'h0, page_valid: 16'h0000, busy: 1'b0,
                     prog_idx: 5'h00, prog_cnt: 16'h0000};
        end else begin
            l_q <= l_d;
        end
    end

    // Array writes; storage changes only through the two-wire protocol.
    always_ff @(posedge ee_clk) begin
        if (mem_we) begin
            mem_q[mem_wa] <= mem_wd; // RQ6
        end
        if (pbuf_we) begin
            pbuf_q[pbuf_wa] <= pbuf_wd;
        end
    end

endmodule // eetwp_top

// ---- src/eetwp_pkg.sv ----
// Constants and types for the EEPROM two-wire port block.
// Assumes an APB register bus on pclk and a free-running link clock for the EEPROM side.
package eetwp_pkg;

    // Byte address of the port register on the APB bus.
    localparam logic [11:0] EETWP_PORT_OFFSET = 12'h090;

    // Field positions inside the port register.
    localparam int unsigned EETWP_CLOCK_BIT_POS = 2;
    localparam int unsigned EETWP_DATA_BIT_POS = 1;
    localparam int unsigned EETWP_POWER_BIT_POS = 0;

    // Reset value of the three port bits: clock high, data released, power on.
    localparam logic [2:0] EETWP_PORT_RESET = 3'h7;

    // Storage geometry: 128 bytes and a sixteen byte write page.
    localparam int unsigned EETWP_MEM_BYTES = 128;
    localparam int unsigned EETWP_PAGE_BYTES = 16;

    // Upper four bits of the control byte that select this memory.
    localparam logic [3:0] EETWP_DEV_CODE = 4'hA;

    // Length of an internal programming cycle in link clock cycles.
    localparam logic [15:0] EETWP_PROG_CYCLES = 16'h03E8;

    // Bits per byte on the wire, and the count at which a byte is complete.
    localparam logic [3:0] EETWP_BYTE_BITS = 4'h8;

    // Protocol states of the memory, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_RACK = 5'h10
    } eetwp_link_state_type;

endpackage : eetwp_pkg

// ---- dv/eetwp_top_chk.sv ----
// Checker for the EEPROM two-wire port: APB answer timing and pin behaviour.
// Assumes it is bound to the design top and sees only that module's ports.
`timescale 1ns/100ps
module eetwp_top_chk
    import eetwp_pkg::*;
(
    // Register bus clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave signals.
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Link clock and memory pins.
    input wire logic ee_clk,
    input wire logic ee_vdd_o,
    input wire logic ee_scl_o,
    input wire logic ee_scl_oe_n,
    input wire logic ee_sda_o,
    input wire logic ee_sda_oe_n
);
    // Everything is judged on the register clock; reset silences all checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A completed write to the port with its low byte lane enabled.
    wire port_wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

    setup_gets_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    unmapped_error_a: assert property (psel && !penable
        && paddr[11:2] != EETWP_PORT_OFFSET[11:2] |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    upper_bits_zero_a: assert property (pready && !pwrite |-> prdata[31:3] == 29'h0)
        else $error("unused read bits not zero");
    off_reads_zero_a: assert property (pready && !pwrite && !ee_vdd_o |-> prdata[2:0] == 3'h0)
        else $error("read while powered off not zero");
    on_reads_power_a: assert property (pready && !pwrite && !pslverr && ee_vdd_o |-> prdata[0])
        else $error("power bit reads wrong");
    power_pin_follows_a: assert property (port_wr |-> ##2 ee_vdd_o == $past(pwdata[0], 2))
        else $error("supply pin does not follow power bit");
    clock_pin_follows_a: assert property (port_wr && pwdata[0]
        |-> ##2 ee_scl_o == $past(pwdata[2], 2) && !ee_scl_oe_n)
        else $error("clock pin does not follow clock bit");
    data_low_drives_a: assert property (port_wr && pwdata[0] && !pwdata[1] |-> ##2 !ee_sda_oe_n)
        else $error("data pin not pulled low");
    off_pins_float_a: assert property (!ee_vdd_o && $past(!ee_vdd_o)
        |-> ee_scl_oe_n && ee_sda_oe_n)
        else $error("pins driven while powered off");

    // Main scenarios: power-off write, refused access, powered-off read.
    cover property (port_wr && !pwdata[0]);
    cover property (pready && pslverr);
    cover property (pready && !pwrite && !ee_vdd_o);
endmodule // eetwp_top_chk

bind eetwp_top eetwp_top_chk u_chk (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .ee_clk, .ee_vdd_o, .ee_scl_o, .ee_scl_oe_n, .ee_sda_o, .ee_sda_oe_n
);

// ---- dv/eetwp_wire_model.sv ----
// Wire model of the two-wire bus: pull-ups and bus condition counters.
// Assumes only the port's pin outputs drive the lines.
`timescale 1ns/100ps
module eetwp_wire_model (
    // Counter reset.
    input wire logic rst_n,
    // Pin outputs of the port.
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // Resolved lines and condition counts.
    output logic scl_line,
    output logic sda_line,
    output int n_start,
    output int n_stop
);
    // A released line floats to the pull-up, so power-off leaves both high.
    assign scl_line = scl_oe_n ? 1'h1 : scl_o;
    assign sda_line = sda_oe_n ? 1'h1 : sda_o;

    // Data falling while the clock is high opens a command.
    always @(negedge sda_line or negedge rst_n) begin
        if (!rst_n) begin
            n_start <= 0;
        end else if (scl_line === 1'h1) begin
            n_start <= n_start + 1;
        end
    end

    // Data rising while the clock is high closes an operation.
    always @(posedge sda_line or negedge rst_n) begin
        if (!rst_n) begin
            n_stop <= 0;
        end else if (scl_line === 1'h1) begin
            n_stop <= n_stop + 1;
        end
    end
endmodule // eetwp_wire_model

// ---- dv/eetwp_top_tb.sv ----
// Testbench for the EEPROM two-wire port: register access and software bus cycles.
// Assumes the design, the wire model and the bound checker are compiled first.
`timescale 1ns/100ps
module eetwp_top_tb;
    import eetwp_pkg::*;
    // Bench drive, design answers and resolved lines.
    logic pclk, ee_clk, presetn, psel, penable, pwrite, rerr, ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb;
    logic pready, pslverr, ee_vdd_o, ee_scl_o, ee_scl_oe_n, ee_sda_o, ee_sda_oe_n;
    logic scl_line, sda_line;
    logic [7:0] rx;
    int n_start, n_stop, n_fail, samples_checked;

    // Register clock at 40 ns and an unrelated link clock at 160 ns.
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        ee_clk = 1'h0;
        #7;
        forever #80 ee_clk = ~ee_clk;
    end

    eetwp_top u_dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .ee_clk, .ee_vdd_o, .ee_scl_o, .ee_scl_oe_n, .ee_sda_o,
        .ee_sda_oe_n
    );
    eetwp_wire_model u_wire (
        .rst_n(presetn), .scl_o(ee_scl_o), .scl_oe_n(ee_scl_oe_n), .sda_o(ee_sda_o),
        .sda_oe_n(ee_sda_oe_n), .scl_line, .sda_line, .n_start, .n_stop
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until the edge that samples pready high.
    // Read data is taken at that same edge, and only the watchdog ends a wait.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Port write, then over 1 us of settling so the memory sees the level.
    task automatic wr(input logic [2:0] v);
        apb(1'h1, EETWP_PORT_OFFSET, {29'h0, v});
        repeat (30) @(posedge pclk);
    endtask

    // One bit: data set with clock low, the line read back while clock is high.
    task automatic clk_bit(input logic b, output logic r);
        wr({1'h0, b, 1'h1});
        wr({1'h1, b, 1'h1});
        apb(1'h0, EETWP_PORT_OFFSET, 32'h0);
        r = rdata[1];
        wr({1'h0, b, 1'h1});
    endtask

    // Eight bits MSB first, then the ninth clock of the acknowledge slot.
    task automatic xbyte(input logic [7:0] tx, input logic nb,
                         output logic [7:0] rxb, output logic a);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rxb[i]);
        end
        clk_bit(nb, a);
    endtask

    task automatic bus_start;
        wr(3'h3);
        wr(3'h7);
        wr(3'h5);
        wr(3'h1);
    endtask

    task automatic bus_stop;
        wr(3'h1);
        wr(3'h5);
        wr(3'h7);
    endtask

    // Reset value, an unmapped address, and a write with its byte lane off.
    task automatic t_regs;
        apb(1'h0, EETWP_PORT_OFFSET, 32'h0);
        chk(rdata, 32'h7);
        apb(1'h0, 12'h094, 32'h0);
        chk({rerr, rdata[30:0]}, 32'h80000000);
        pstrb <= 4'h0;
        apb(1'h1, EETWP_PORT_OFFSET, 32'h0);
        pstrb <= 4'hF;
        apb(1'h0, EETWP_PORT_OFFSET, 32'h0);
        chk(rdata, 32'h7);
    endtask

    // Each bit reaches its pin, and the data line reads back as the wire level.
    task automatic t_pins;
        wr(3'h3);
        chk({ee_scl_o, ee_scl_oe_n}, 32'h0);
        wr(3'h1);
        chk(ee_sda_oe_n, 32'h0);
        apb(1'h0, EETWP_PORT_OFFSET, 32'h0);
        chk(rdata, 32'h1);
        wr(3'h3);
        chk({ee_sda_oe_n, sda_line}, 32'h3);
        wr(3'h7);
        chk({ee_scl_o, ee_vdd_o}, 32'h3);
    endtask

    // Power off floats the pins and hides the written bits.
    task automatic t_power;
        wr(3'h6);
        chk({ee_vdd_o, ee_scl_oe_n, ee_sda_oe_n}, 32'h3);
        apb(1'h0, EETWP_PORT_OFFSET, 32'h0);
        chk(rdata, 32'h0);
        wr(3'h7);
    endtask

    // Seventeen bytes into one page, then a probe while programming runs.
    task automatic t_write;
        bus_start;
        xbyte(8'hA0, 1'h1, rx, ack);
        chk(ack, 32'h0);
        xbyte(8'h10, 1'h1, rx, ack);
        chk(ack, 32'h0);
        for (int k = 0; k < 17; k++) begin
            xbyte(8'h30 + 8'(k), 1'h1, rx, ack);
            chk(ack, 32'h0);
        end
        bus_stop;
        bus_start;
        xbyte(8'hA0, 1'h1, rx, ack);
        chk(ack, 32'h1);
        bus_stop;
        repeat (4500) @(posedge pclk);
    endtask

    // Random read: the seventeenth byte replaced the first; nack ends the read.
    task automatic t_read;
        bus_start;
        xbyte(8'hA0, 1'h1, rx, ack);
        xbyte(8'h10, 1'h1, rx, ack);
        bus_start;
        xbyte(8'hA1, 1'h1, rx, ack);
        chk(ack, 32'h0);
        xbyte(8'hFF, 1'h0, rx, ack);
        chk(rx, 32'h40);
        xbyte(8'hFF, 1'h1, rx, ack);
        chk({rx, 7'h0, ack}, 32'h3101);
        bus_stop;
        chk({n_start[7:0], n_stop[7:0]}, 32'h0403);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence: six cycles of reset, then the scenarios in turn.
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        n_fail = 0;
        samples_checked = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_pins;
        t_power;
        t_write;
        t_read;
        summarize;
    end

    // The scenarios need about 30000 cycles; twice that means a hang.
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        summarize;
    end
endmodule // eetwp_top_tb
